// ==== logic/scs_system_control.sv ====
// system control and status register with bus clear, lock and wait logic
// Behaviour
// - 32-bit read-write register at 0f4, answered only in supervisor data space
// - top four bits are event flags set by hardware, always readable
// - writing one clears a flag, zero leaves it; several at once
// - system reset (reset with halt) clears all flags
// - pending unmasked core interrupt sets the interrupt flag regardless of mask
// - interrupt flag with bus clear mask drives external and internal bus clear
// - watchdog expiry sets its flag and always raises bus error
// - write to read-only region sets flag; bus error only with bit 20
// - two or more chip selects set conflict flag; bus error only with bit 17
// - never two chip selects at once; fixed priority resolves overlap
// - conflicts during configuration register access are ignored entirely
// - split off: strobes held over locked cycle, waits on read part only
// - split on: strobes drop between parts, waits in both parts
// - no bus grant while core locked sequence is in progress
// - extra wait bit adds one wait state to external master cycles, except async internal ones and seven-wait ones
// - extra wait clear: sync internal zero waits, chip select exact waits
// - mask zero ignores core interrupt pending for bus clear
// - serial dma bus use does not depend on the bus clear mask
// - sync select zero: external master internal accesses take three waits
// - sync select one: synchronous accesses, one wait with extra wait bit
// - control bits read zero after system reset
// - external bus clear holds until the interrupt flag is cleared
`timescale 1ns/1ps
`default_nettype none
module scs_system_control (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic reset_pin_n_in,
  input wire logic halt_pin_n_in,
  input wire scs_pkg::scs_req_t req_in,
  input wire logic [3:0] cs_match_in,
  input wire logic [3:0] cs_read_only_in,
  input wire logic [2:0] cs_waits_in,
  input wire logic core_interrupt_pending_in,
  input wire logic watchdog_expire_in,
  input wire logic address_strobe_in,
  input wire logic locked_cycle_indicator_in,
  input wire logic rmw_write_part_in,
  input wire logic rmw_gap_in,
  input wire logic bus_request_in,
  output logic [31:0] rdata_out,
  output logic transfer_acknowledge_out,
  output logic bus_error_signal_out,
  output logic [3:0] chip_select_out,
  output logic address_strobe_out,
  output logic bus_grant_out,
  output logic external_bus_clear_out,
  output logic internal_bus_clear_out,
  output logic [3:0] status_flags_out
);
  scs_pkg::scs_state_t s_q;
  scs_pkg::scs_state_t s_d;

  logic sys_reset;
  logic scr_hit;
  logic [3:0] sel;
  logic multi;
  logic wp_event;
  logic adc_event;
  logic [3:0] set_ev;
  logic [3:0] clr_ev;
  logic [2:0] waits;
  logic [31:0] scr_value;

  // system reset needs both pins low after synchronising
  assign sys_reset = ~s_q.rst_sync[1] & ~s_q.halt_sync[1];

  // decode only supervisor data space at the fixed address
  assign scr_hit = req_in.start & (req_in.addr == scs_pkg::SCS_SCR_ADDR)
                   & (req_in.fc == scs_pkg::SCS_FC_SUPER_DATA);

  // lowest index wins so an overlap never drives two lines
  always_comb begin
    sel = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (cs_match_in[i]) begin
        sel = 4'h0;
        sel[i] = 1'b1;
      end
    end
  end

  assign multi = (cs_match_in & (cs_match_in - 4'h1)) != 4'h0;
  // configuration access must stay reachable while programming is broken
  assign adc_event = req_in.start & multi & ~(req_in.cfg | scr_hit);
  assign wp_event = req_in.start & req_in.write & ((sel & cs_read_only_in) != 4'h0);

  // flag order: irq, watchdog, write protect, decode conflict
  assign set_ev = {core_interrupt_pending_in, watchdog_expire_in, wp_event, adc_event};
  assign clr_ev = (scr_hit & req_in.write) ? req_in.wdata[31:28] : 4'h0;

  // register image; unused bits read zero
  always_comb begin
    scr_value = 32'h00000000;
    scr_value[31:28] = s_q.flags;
    scr_value[scs_pkg::SCS_WRITE_PROTECT_ERROR_ENABLE_BIT] = s_q.write_protect_error_enable;
    scr_value[scs_pkg::SCS_SPLIT_BIT] = s_q.split;
    scr_value[scs_pkg::SCS_EXTERNAL_MASTER_EXTRA_WAIT_BIT] = s_q.external_master_extra_wait;
    scr_value[scs_pkg::SCS_DECODE_CONFLICT_ERROR_ENABLE_BIT] = s_q.decode_conflict_error_enable;
    scr_value[scs_pkg::SCS_BUS_CLEAR_INTERRUPT_MASK_BIT] = s_q.bus_clear_interrupt_mask;
    scr_value[scs_pkg::SCS_SAM_BIT] = s_q.sync_access_select;
  end

  // wait states for the access that starts this cycle
  always_comb begin
    waits = scs_pkg::SCS_ZERO_WAITS;
    if (req_in.internal | scr_hit) begin
      if (req_in.ext_master & ~s_q.sync_access_select) begin
        waits = scs_pkg::SCS_ASYNC_WAITS;
      end else if (req_in.ext_master & s_q.external_master_extra_wait) begin
        waits = scs_pkg::SCS_EXTRA_WAIT;
      end
    end else begin
      // locked write part without split gets no chip-select waits
      if (locked_cycle_indicator_in & rmw_write_part_in & ~s_q.split) begin
        waits = scs_pkg::SCS_ZERO_WAITS;
      end else begin
        waits = cs_waits_in;
      end
      if (req_in.ext_master & s_q.external_master_extra_wait & (waits != 3'h7)) begin
        waits = waits + scs_pkg::SCS_EXTRA_WAIT;
      end
    end
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], reset_pin_n_in};
    s_d.halt_sync = {s_q.halt_sync[0], halt_pin_n_in};
    // set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr_ev) | set_ev;
    s_d.bus_error_signal = watchdog_expire_in
               | (wp_event & s_q.write_protect_error_enable)
               | (adc_event & s_q.decode_conflict_error_enable);
    if (scr_hit & req_in.write) begin
      s_d.write_protect_error_enable = req_in.wdata[scs_pkg::SCS_WRITE_PROTECT_ERROR_ENABLE_BIT];
      s_d.split = req_in.wdata[scs_pkg::SCS_SPLIT_BIT];
      s_d.external_master_extra_wait = req_in.wdata[scs_pkg::SCS_EXTERNAL_MASTER_EXTRA_WAIT_BIT];
      s_d.decode_conflict_error_enable = req_in.wdata[scs_pkg::SCS_DECODE_CONFLICT_ERROR_ENABLE_BIT];
      s_d.bus_clear_interrupt_mask = req_in.wdata[scs_pkg::SCS_BUS_CLEAR_INTERRUPT_MASK_BIT];
      s_d.sync_access_select = req_in.wdata[scs_pkg::SCS_SAM_BIT];
    end
    if (scr_hit & ~req_in.write) begin
      s_d.rdata = scr_value;
    end
    // acknowledge counter; a new start while busy is ignored
    if (s_q.busy) begin
      if (s_q.cnt == 3'h0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 3'h1;
      end
    end else if (req_in.start) begin
      s_d.busy = 1'b1;
      s_d.cnt = waits;
    end
    if (sys_reset) begin
      s_d.flags = scs_pkg::SCS_FLAGS_RST;
      s_d.write_protect_error_enable = scs_pkg::SCS_CTRL_RST;
      s_d.split = scs_pkg::SCS_CTRL_RST;
      s_d.external_master_extra_wait = scs_pkg::SCS_CTRL_RST;
      s_d.decode_conflict_error_enable = scs_pkg::SCS_CTRL_RST;
      s_d.bus_clear_interrupt_mask = scs_pkg::SCS_CTRL_RST;
      s_d.sync_access_select = scs_pkg::SCS_CTRL_RST;
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.rst_sync <= scs_pkg::SCS_SYNC_RST;
      s_q.halt_sync <= scs_pkg::SCS_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // strobe drops between locked parts only in split mode
  assign address_strobe_out = address_strobe_in
                              & ~(s_q.split & locked_cycle_indicator_in & rmw_gap_in);
  assign chip_select_out = sel & {4{address_strobe_out}};
  // no grant during a core locked sequence in either mode
  assign bus_grant_out = bus_request_in & ~locked_cycle_indicator_in;
  // held until software clears the flag; serial dma is not gated here
  assign external_bus_clear_out = s_q.flags[3] & s_q.bus_clear_interrupt_mask;
  assign internal_bus_clear_out = s_q.flags[3] & s_q.bus_clear_interrupt_mask;
  assign transfer_acknowledge_out = s_q.busy & (s_q.cnt == 3'h0);
  assign bus_error_signal_out = s_q.bus_error_signal;
  assign rdata_out = s_q.rdata;
  assign status_flags_out = s_q.flags;

  // checks
  chk_irq_sets_flag: assert property (@(posedge clock_in) disable iff (reset_in)
    core_interrupt_pending_in && !sys_reset |=> status_flags_out[3])
    else $error("irq flag not set");
  chk_clear_by_one: assert property (@(posedge clock_in) disable iff (reset_in)
    scr_hit && req_in.write && req_in.wdata[30] && !watchdog_expire_in |=> !status_flags_out[2])
    else $error("watchdog flag not cleared by one");
  chk_zero_keeps: assert property (@(posedge clock_in) disable iff (reset_in)
    scr_hit && req_in.write && !req_in.wdata[29] && status_flags_out[1] && !sys_reset
    |=> status_flags_out[1])
    else $error("flag lost on zero write");
  chk_set_wins: assert property (@(posedge clock_in) disable iff (reset_in)
    scr_hit && req_in.write && req_in.wdata[31] && core_interrupt_pending_in && !sys_reset
    |=> status_flags_out[3])
    else $error("event lost in clear cycle");
  chk_sysrst_clears: assert property (@(posedge clock_in) disable iff (reset_in)
    sys_reset |=> status_flags_out == 4'h0 && !external_bus_clear_out)
    else $error("system reset left state");
  chk_external_bus_clear_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    external_bus_clear_out |-> status_flags_out[3] && internal_bus_clear_out)
    else $error("bus clear without flag");
  chk_wdt_bus_error_signal: assert property (@(posedge clock_in) disable iff (reset_in)
    watchdog_expire_in |=> bus_error_signal_out)
    else $error("no bus error after watchdog");
  chk_wp_no_bus_error_signal: assert property (@(posedge clock_in) disable iff (reset_in)
    wp_event && !s_q.write_protect_error_enable && !watchdog_expire_in && !(adc_event && s_q.decode_conflict_error_enable)
    |=> !bus_error_signal_out && status_flags_out[1])
    else $error("write protect error enable ignored");
  chk_cs_onehot: assert property (@(posedge clock_in) disable iff (reset_in)
    $onehot0(chip_select_out))
    else $error("two chip selects");
  chk_cfg_no_bus_error_signal: assert property (@(posedge clock_in) disable iff (reset_in)
    req_in.start && req_in.cfg && multi && !watchdog_expire_in && !wp_event
    |=> !bus_error_signal_out)
    else $error("conflict reported on config access");
  chk_grant_lock: assert property (@(posedge clock_in) disable iff (reset_in)
    locked_cycle_indicator_in |-> !bus_grant_out)
    else $error("grant during lock");
  chk_async_waits: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.busy && req_in.start && req_in.internal && req_in.ext_master && !s_q.sync_access_select
    |=> !transfer_acknowledge_out [*3] ##1 transfer_acknowledge_out)
    else $error("async access not three waits");

  // wait state checks on the acknowledge counter
  chk_sync_extra_wait: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.busy && req_in.start && req_in.internal && req_in.ext_master && s_q.sync_access_select && s_q.external_master_extra_wait
    |=> !transfer_acknowledge_out ##1 transfer_acknowledge_out)
    else $error("sync access with extra wait not one wait");
  chk_sync_zero_wait: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.busy && req_in.start && req_in.internal && req_in.ext_master && s_q.sync_access_select && !s_q.external_master_extra_wait
    |=> transfer_acknowledge_out)
    else $error("sync access not zero waits");
  chk_core_zero_wait: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.busy && req_in.start && req_in.internal && !req_in.ext_master
    |=> transfer_acknowledge_out)
    else $error("core internal access not zero waits");
  chk_ack_single: assert property (@(posedge clock_in) disable iff (reset_in)
    transfer_acknowledge_out |=> !transfer_acknowledge_out)
    else $error("acknowledge longer than one cycle");

  // bus error and flag checks; a flag set by hardware must survive one edge
  chk_wp_bus_error_signal: assert property (@(posedge clock_in) disable iff (reset_in)
    wp_event && s_q.write_protect_error_enable |=> bus_error_signal_out)
    else $error("no bus error on enabled write protect");
  chk_wp_sets: assert property (@(posedge clock_in) disable iff (reset_in)
    wp_event && !sys_reset |=> status_flags_out[1])
    else $error("write protect flag not set");
  chk_adc_bus_error_signal: assert property (@(posedge clock_in) disable iff (reset_in)
    adc_event && s_q.decode_conflict_error_enable |=> bus_error_signal_out)
    else $error("no bus error on enabled conflict");
  chk_adc_sets: assert property (@(posedge clock_in) disable iff (reset_in)
    adc_event && !sys_reset |=> status_flags_out[0])
    else $error("conflict flag not set");
  chk_wdt_sets: assert property (@(posedge clock_in) disable iff (reset_in)
    watchdog_expire_in && !sys_reset |=> status_flags_out[2])
    else $error("watchdog flag not set");

  // bus clear checks; the mask alone gates both outputs
  chk_bus_clear_interrupt_mask_off: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.bus_clear_interrupt_mask |-> !external_bus_clear_out && !internal_bus_clear_out)
    else $error("bus clear with mask off");
  chk_external_bus_clear_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    external_bus_clear_out && !(scr_hit && req_in.write) && !sys_reset
    |=> external_bus_clear_out)
    else $error("bus clear dropped while flag set");

  // strobe and system reset checks
  chk_split_gap: assert property (@(posedge clock_in) disable iff (reset_in)
    s_q.split && locked_cycle_indicator_in && rmw_gap_in
    |-> !address_strobe_out && chip_select_out == 4'h0)
    else $error("strobe kept between split parts");
  chk_nosplit_as: assert property (@(posedge clock_in) disable iff (reset_in)
    !s_q.split |-> address_strobe_out == address_strobe_in)
    else $error("strobe dropped without split");
  chk_ctrl_reset: assert property (@(posedge clock_in) disable iff (reset_in)
    sys_reset |=> !s_q.write_protect_error_enable && !s_q.split && !s_q.external_master_extra_wait && !s_q.decode_conflict_error_enable && !s_q.bus_clear_interrupt_mask)
    else $error("control bits kept over system reset");

  cov_async_read: cover property (@(posedge clock_in) disable iff (reset_in)
    req_in.start && req_in.ext_master && !s_q.sync_access_select ##4 transfer_acknowledge_out);
  cov_wp_bus_error_signal: cover property (@(posedge clock_in) disable iff (reset_in)
    wp_event && s_q.write_protect_error_enable ##1 bus_error_signal_out);

  cov_irq_external_bus_clear: cover property (@(posedge clock_in) disable iff (reset_in)
    external_bus_clear_out ##1 !external_bus_clear_out);
  cov_conflict_bus_error_signal: cover property (@(posedge clock_in) disable iff (reset_in)
    adc_event && s_q.decode_conflict_error_enable ##1 bus_error_signal_out);
  cov_split_gap: cover property (@(posedge clock_in) disable iff (reset_in)
    s_q.split && locked_cycle_indicator_in && rmw_gap_in && address_strobe_in);
endmodule
`default_nettype wire

// ==== shared/scs_pkg.sv ====
// system control and status register: constants and carrier types
package scs_pkg;
  localparam logic [23:0] SCS_SCR_ADDR = 24'h0000f4;
  localparam logic [2:0] SCS_FC_SUPER_DATA = 3'h5;
  // status flag positions, top four bits
  localparam int SCS_IRQ_BIT = 31;
  localparam int SCS_WDT_BIT = 30;
  localparam int SCS_WPV_BIT = 29;
  localparam int SCS_ADC_BIT = 28;
  // control bit positions
  localparam int SCS_WRITE_PROTECT_ERROR_ENABLE_BIT = 20;
  localparam int SCS_SPLIT_BIT = 19;
  localparam int SCS_EXTERNAL_MASTER_EXTRA_WAIT_BIT = 18;
  localparam int SCS_DECODE_CONFLICT_ERROR_ENABLE_BIT = 17;
  localparam int SCS_BUS_CLEAR_INTERRUPT_MASK_BIT = 16;
  localparam int SCS_SAM_BIT = 15;
  // values after reset
  localparam logic [3:0] SCS_FLAGS_RST = 4'h0;
  localparam logic SCS_CTRL_RST = 1'h0;
  localparam logic [1:0] SCS_SYNC_RST = 2'h3;
  // wait state counts
  localparam logic [2:0] SCS_ASYNC_WAITS = 3'h3;
  localparam logic [2:0] SCS_ZERO_WAITS = 3'h0;
  localparam logic [2:0] SCS_EXTRA_WAIT = 3'h1;

  // one bus access, valid in the cycle of start
  typedef struct packed {
    logic start;
    logic write;
    logic [2:0] fc;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic ext_master;
    logic internal;
    logic cfg;
  } scs_req_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] halt_sync;
    logic [3:0] flags;
    logic write_protect_error_enable;
    logic split;
    logic external_master_extra_wait;
    logic decode_conflict_error_enable;
    logic bus_clear_interrupt_mask;
    logic sync_access_select;
    logic busy;
    logic [2:0] cnt;
    logic [31:0] rdata;
    logic bus_error_signal;
  } scs_state_t;
endpackage

// ==== verification/scs_master_model.sv ====
// bus master partner: one request per go, times the answer
`timescale 1ns/1ps
`default_nettype none
module scs_master_model (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic go_in,
  input wire scs_pkg::scs_req_t tmpl_in,
  input wire logic transfer_acknowledge_in,
  output scs_pkg::scs_req_t req_out,
  output logic busy_out,
  output logic [7:0] lat_out
);
  logic [7:0] cnt_q;
  // idle address and data toggle so a stale value never looks valid
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      req_out <= '0;
      busy_out <= 1'b0;
      cnt_q <= 8'h00;
      lat_out <= 8'h00;
    end else if (go_in && !busy_out) begin
      req_out <= tmpl_in;
      req_out.start <= 1'b1;
      busy_out <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      req_out.start <= 1'b0;
      req_out.addr <= ~req_out.addr;
      req_out.wdata <= ~req_out.wdata;
      cnt_q <= cnt_q + 8'h01;
      if (busy_out && transfer_acknowledge_in) begin
        busy_out <= 1'b0;
        lat_out <= cnt_q; // edges from take to answer, waits plus one
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/scs_system_control_tb.sv ====
// testbench for the system control register block
`timescale 1ns/1ps
`default_nettype none
module scs_system_control_tb;
  typedef struct packed {
    logic [2:0] fc;
    logic [31:0] d;
    logic ext;
    logic [31:0] exp;
    logic [7:0] lat;
  } scs_row_t;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic rp_n = 1'b1, hp_n = 1'b1, go = 1'b0, arm = 1'b0, irq = 1'b0, wd = 1'b0;
  logic as_in = 1'b0, lk = 1'b0, wp = 1'b0, gap = 1'b0, br = 1'b0;
  logic [3:0] csm = 4'h0, cro = 4'h0, cs, fl;
  scs_pkg::scs_req_t tm = '0, req;
  logic [31:0] rdata;
  logic ack, bus_error_signal, bg, as_o, ebc, ibc, busy;
  logic [7:0] lat;
  int miscompares = 0, samples_checked = 0, cyc = 0, nberr = 0;
  // core writes with fc, then reads back as core or external master
  scs_row_t rows [7] = '{'{3'h5, 32'h0, 1'b1, 32'h0, 8'h04},
    '{3'h5, 32'h8000, 1'b1, 32'h8000, 8'h01}, '{3'h5, 32'h48000, 1'b1, 32'h48000, 8'h02},
    '{3'h3, 32'h0, 1'b0, 32'h48000, 8'h01}, '{3'h5, 32'h1f8000, 1'b0, 32'h1f8000, 8'h01},
    '{3'h5, 32'hff000000, 1'b0, 32'h0, 8'h01}, '{3'h5, 32'h0, 1'b0, 32'h0, 8'h01}};
  always #12.5 clock_in = ~clock_in;
  scs_master_model master (.clock_in(clock_in), .reset_in(reset_in), .go_in(go),
    .tmpl_in(tm), .transfer_acknowledge_in(ack), .req_out(req), .busy_out(busy), .lat_out(lat));
  scs_system_control DUT (.clock_in(clock_in), .reset_in(reset_in), .reset_pin_n_in(rp_n),
    .halt_pin_n_in(hp_n), .req_in(req), .cs_match_in(csm), .cs_read_only_in(cro),
    .cs_waits_in(3'h2), .core_interrupt_pending_in(irq), .watchdog_expire_in(wd),
    .address_strobe_in(as_in), .locked_cycle_indicator_in(lk), .rmw_write_part_in(wp),
    .rmw_gap_in(gap), .bus_request_in(br), .rdata_out(rdata), .transfer_acknowledge_out(ack),
    .bus_error_signal_out(bus_error_signal), .chip_select_out(cs), .address_strobe_out(as_o),
    .bus_grant_out(bg), .external_bus_clear_out(ebc), .internal_bus_clear_out(ibc),
    .status_flags_out(fl));
  // bus error pulses counted, hang cut short
  always @(posedge clock_in) begin
    cyc++;
    if (bus_error_signal === 1'b1) nberr++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clock_in);
    #1;
  endtask
  // arm puts a watchdog event on the edge that takes the request
  task acc(input logic w, input logic [2:0] fc, input logic [23:0] a, input logic [31:0] d,
    input logic ext);
    tm.write = w;
    tm.fc = fc;
    tm.addr = a;
    tm.wdata = d;
    tm.ext_master = ext;
    go = 1'b1;
    tick();
    go = 1'b0;
    wd = arm;
    tick();
    wd = 1'b0;
    for (int i = 0; i < 30 && busy; i++) tick();
  endtask
  task wr(input logic [31:0] d);
    acc(1'b1, scs_pkg::SCS_FC_SUPER_DATA, scs_pkg::SCS_SCR_ADDR, d, 1'b0);
  endtask
  initial begin
    tm.internal = 1'b1;
    repeat (12) @(posedge clock_in);
    #1 reset_in = 1'b0;
    acc(1'b0, 3'h5, scs_pkg::SCS_SCR_ADDR, 32'h0, 1'b0);
    chk(rdata, 32'h0);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].fc, scs_pkg::SCS_SCR_ADDR, rows[i].d, 1'b0);
      acc(1'b0, 3'h5, scs_pkg::SCS_SCR_ADDR, 32'h0, rows[i].ext);
      chk(rdata, rows[i].exp);
      chk({24'h0, lat}, {24'h0, rows[i].lat});
    end
    irq = 1'b1;
    tick();
    irq = 1'b0;
    tick();
    chk({ebc, fl}, 5'h08);
    wr(32'h10000);
    chk({ebc, ibc, fl}, 6'h38);
    wr(32'h80010000);
    chk({ebc, fl}, 5'h00);
    nberr = 0;
    repeat (2) begin
      wd = 1'b1;
      tick();
      wd = 1'b0;
      tick();
    end
    chk({nberr[3:0], fl}, 8'h24);
    arm = 1'b1;
    wr(32'h40000000);
    arm = 1'b0;
    chk(fl, 4'h4);
    wr(32'hf0000000);
    chk(fl, 4'h0);
    tm.internal = 1'b0;
    csm = 4'h1;
    cro = 4'h1;
    as_in = 1'b1;
    nberr = 0;
    acc(1'b1, 3'h5, 24'h200000, 32'h0, 1'b0);
    chk({nberr[3:0], fl, lat}, 16'h0203);
    wr(32'h100000);
    acc(1'b1, 3'h5, 24'h200000, 32'h0, 1'b0);
    chk(nberr, 1);
    wr(32'h20000);
    csm = 4'h3;
    cro = 4'h0;
    tm.cfg = 1'b1;
    nberr = 0;
    acc(1'b0, 3'h5, 24'h200000, 32'h0, 1'b0);
    chk({nberr[3:0], fl}, 8'h02);
    tm.cfg = 1'b0;
    acc(1'b0, 3'h5, 24'h200000, 32'h0, 1'b0);
    chk({nberr[3:0], fl}, 8'h13);
    csm = 4'h6;
    br = 1'b1;
    lk = 1'b1;
    #1 chk({cs, bg}, 5'h04);
    lk = 1'b0;
    #1 chk(bg, 1'b1);
    tm.internal = 1'b1;
    wr(32'h80000);
    lk = 1'b1;
    gap = 1'b1;
    #1 chk(as_o, 1'b0);
    wr(32'h0);
    chk(as_o, 1'b1);
    lk = 1'b0;
    wr(32'h1f8000);
    rp_n = 1'b0;
    hp_n = 1'b0;
    repeat (4) tick();
    rp_n = 1'b1;
    hp_n = 1'b1;
    repeat (3) tick();
    acc(1'b0, 3'h5, scs_pkg::SCS_SCR_ADDR, 32'h0, 1'b0);
    chk(rdata, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
